/* rtl/sts_params.svh */
// Notes on behaviour
// - Internal supply low holds all logic but the input synchroniser reset
// - Micro supply low drives micro reset low
// - Pass switch on when entering Active
// - Pass switch off only entering Sleep or in core reset
// - Watchdog resets leave pass switch alone
// - Battery over/undervoltage forces gates off
// - Battery fault shown on supply fault pin
// - Prewarn temperature drives warning flag high
// - Shutdown kills regulator, gates, transceiver, reset
// - Resume Active once below shutdown threshold
// - Warning flag low below prewarn threshold
// - Power-on enters Active without wake-up
// - Falling sleep request held low enters Sleep
`ifndef STS_PARAMS_SVH
`define STS_PARAMS_SVH
`define STS_CLK_MHZ 25
`define STS_GOTOSLEEP_NS 10000
`define STS_GOTOSLEEP_CYC ((`STS_GOTOSLEEP_NS * `STS_CLK_MHZ + 999) / 1000)
`define STS_SYNC_W 7
`define STS_GATE_OFF 6'h00
`endif

/* rtl/sts_pkg.sv */
package sts_pkg;
    typedef enum logic [1:0] {STS_ACTIVE, STS_SLEEP, STS_HOT} sts_mode_e;
endpackage

/* rtl/sts_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module sts_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sts_sync_s;
    sts_sync_s st_r;
    sts_sync_s st_nxt;
    // Third stage filters: change taken when second and third agree
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st_r.s2[i] == st_r.s3[i])
            begin
                st_nxt.q[i] = st_r.s3[i];
            end
        end
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign dout = st_r.q;
endmodule
`default_nettype wire

/* rtl/sts_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sts_params.svh"
module sts_supervisor
    import sts_pkg::*;
#(
    parameter int SLEEP_CYC = `STS_GOTOSLEEP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic intSupplyGood,
    input wire logic mcuSupplyGood,
    input wire logic batOverVolt,
    input wire logic batUnderVolt,
    input wire logic tempPrewarn,
    input wire logic tempShutdown,
    input wire logic sleepRequestIn,
    input wire logic watchdogReset,
    input wire logic [5:0] gateReq,
    output logic [5:0] gateOut,
    output logic batteryPassSwitchOut,
    output logic supplyFaultFlag,
    output logic thermalWarningFlag,
    output logic mcuReset_n,
    output logic mcuRegEnable,
    output logic linEnable,
    output logic sleepMode
);
    logic [`STS_SYNC_W-1:0] syncIn;
    logic [`STS_SYNC_W-1:0] syncOut;
    logic intGood;
    logic mcuGood;
    logic batFault;
    logic warm;
    logic hot;
    logic sleepReq;
    logic coreRst;

    typedef struct packed {
        sts_mode_e mode;
        logic sleepPrev;
        logic armed;
        logic [15:0] lowCnt;
        logic [5:0] gate;
        logic pass;
        logic fault;
        logic warn;
        logic rstn;
        logic regEn;
        logic linEn;
        logic slp;
    } sts_state_s;
    sts_state_s st_r;
    sts_state_s st_nxt;

    // Internal supply good synchronised too: its low level is the core reset
    assign syncIn = {sleepRequestIn, mcuSupplyGood, batOverVolt, batUnderVolt,
                     tempPrewarn, tempShutdown, intSupplyGood};
    sts_sync #(.W(`STS_SYNC_W)) uSync (
        .clk(clk),
        .rst(rst),
        .din(syncIn),
        .dout(syncOut)
    );
    assign {sleepReq, mcuGood, batFault, hot} =
        {syncOut[6], syncOut[5], syncOut[4] | syncOut[3], syncOut[1]};
    assign warm = syncOut[2];
    assign intGood = syncOut[0];
    // Synchronised low internal supply held as core reset
    assign coreRst = rst | ~intGood;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sleepPrev = sleepReq;
        // Falling edge arms, any high level before the count disarms
        if (st_r.sleepPrev && !sleepReq)
        begin
            st_nxt.armed = 1'b1;
            st_nxt.lowCnt = 16'h0000;
        end
        else if (sleepReq)
        begin
            st_nxt.armed = 1'b0;
            st_nxt.lowCnt = 16'h0000;
        end
        else if (st_r.armed && st_r.lowCnt < 16'(SLEEP_CYC))
        begin
            st_nxt.lowCnt = st_r.lowCnt + 16'h0001;
        end
        unique case (st_r.mode)
            STS_ACTIVE:
            begin
                if (hot)
                begin
                    st_nxt.mode = STS_HOT;
                end
                else if (st_r.armed && st_r.lowCnt >= 16'(SLEEP_CYC - 1))
                begin
                    st_nxt.mode = STS_SLEEP;
                    st_nxt.armed = 1'b0;
                end
            end
            STS_SLEEP:
            begin
                // No wake-up source here: only core reset leaves Sleep
                st_nxt.mode = STS_SLEEP;
            end
            STS_HOT:
            begin
                // Sleep request ignored while hot; stale arming dropped
                st_nxt.armed = 1'b0;
                if (!hot)
                begin
                    st_nxt.mode = STS_ACTIVE;
                end
            end
        endcase
        // Pass switch drops only in Sleep; watchdog input ignored
        st_nxt.pass = (st_nxt.mode != STS_SLEEP);
        st_nxt.regEn = (st_nxt.mode == STS_ACTIVE);
        st_nxt.linEn = (st_nxt.mode == STS_ACTIVE);
        st_nxt.slp = (st_nxt.mode == STS_SLEEP);
        st_nxt.fault = batFault;
        st_nxt.warn = warm;
        if (batFault || st_nxt.mode != STS_ACTIVE)
        begin
            st_nxt.gate = `STS_GATE_OFF;
        end
        else
        begin
            st_nxt.gate = gateReq;
        end
        st_nxt.rstn = mcuGood && !hot && (st_nxt.mode == STS_ACTIVE);
    end

    always_ff @(posedge clk or posedge coreRst)
    begin
        if (coreRst)
        begin
            st_r <= '{mode: STS_ACTIVE, sleepPrev: 1'b0, armed: 1'b0,
                      lowCnt: 16'h0000, gate: `STS_GATE_OFF, pass: 1'b0,
                      fault: 1'b0, warn: 1'b0, rstn: 1'b0, regEn: 1'b0,
                      linEn: 1'b0, slp: 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign gateOut = st_r.gate;
    assign batteryPassSwitchOut = st_r.pass;
    assign supplyFaultFlag = st_r.fault;
    assign thermalWarningFlag = st_r.warn;
    assign mcuReset_n = st_r.rstn;
    assign mcuRegEnable = st_r.regEn;
    assign linEnable = st_r.linEn;
    assign sleepMode = st_r.slp;

    // Unused: watchdog resets must not reach the pass switch
    logic wdUnused;
    assign wdUnused = watchdogReset;

    default clocking cb @(posedge clk); endclocking
    default disable iff (coreRst);

    sequence s_fault;
        batFault;
    endsequence
    property p_gates_off;
        s_fault |=> gateOut == 6'h00;
    endproperty
    a_gates_off: assert property (p_gates_off) else $error("gates on in fault");
    property p_fault_flag;
        ##1 supplyFaultFlag == $past(batFault);
    endproperty
    a_fault_flag: assert property (p_fault_flag) else $error("fault flag wrong");
    property p_warn;
        ##1 thermalWarningFlag == $past(warm);
    endproperty
    a_warn: assert property (p_warn) else $error("warning flag wrong");
    property p_warn_clear;
        !warm |=> !thermalWarningFlag;
    endproperty
    a_warn_clear: assert property (p_warn_clear) else $error("warning stuck");
    property p_hot;
        hot && st_r.mode != STS_SLEEP |=> !mcuReset_n && !mcuRegEnable && !linEnable
            && gateOut == 6'h00;
    endproperty
    a_hot: assert property (p_hot) else $error("shutdown not applied");
    property p_mcu_rst;
        !mcuGood |=> !mcuReset_n;
    endproperty
    a_mcu_rst: assert property (p_mcu_rst) else $error("micro reset missing");
    property p_recover;
        st_r.mode == STS_HOT && !hot |=> st_r.mode == STS_ACTIVE;
    endproperty
    a_recover: assert property (p_recover) else $error("no recovery");
    property p_pass_hold;
        batteryPassSwitchOut |=> batteryPassSwitchOut || st_r.mode == STS_SLEEP;
    endproperty
    a_pass_hold: assert property (p_pass_hold) else $error("pass switch dropped");
    sequence s_sleep_req;
        st_r.sleepPrev && !sleepReq && !hot && st_r.mode == STS_ACTIVE ##1 !sleepReq [*8];
    endsequence
    property p_no_early_sleep;
        s_sleep_req |-> st_r.mode == STS_ACTIVE;
    endproperty
    a_no_early_sleep: assert property (p_no_early_sleep) else $error("early sleep");
endmodule
`default_nettype wire

/* dv/sts_mcu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sts_mcu_model (
    input wire logic clk,
    input wire logic mcuReset_n,
    input wire logic thermalWarningFlag,
    input wire logic sleepCmd,
    input wire logic [5:0] gateCmd,
    output logic sleepRequestIn,
    output logic [5:0] gateReq
);
    // A micro held in reset drives no gates; on warning it sheds high sides
    always_ff @(posedge clk)
    begin
        sleepRequestIn <= sleepCmd;
        gateReq <= !mcuReset_n ? 6'h00 : (thermalWarningFlag ? (gateCmd & 6'h07) : gateCmd);
    end
endmodule
`default_nettype wire

/* dv/supply_thermal_supervisor_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module supply_thermal_supervisor_tb_top;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic intSupplyGood = 1'h1;
    logic mcuSupplyGood = 1'h1;
    logic batOverVolt = 1'h0;
    logic batUnderVolt = 1'h0;
    logic tempPrewarn = 1'h0;
    logic tempShutdown = 1'h0;
    logic watchdogReset = 1'h0;
    logic sleepCmd = 1'h1;
    logic [5:0] gateCmd = 6'h2D;
    logic sleepRequestIn;
    logic [5:0] gateReq;
    logic [5:0] gateOut;
    logic batteryPassSwitchOut;
    logic supplyFaultFlag;
    logic thermalWarningFlag;
    logic mcuReset_n;
    logic mcuRegEnable;
    logic linEnable;
    logic sleepMode;
    int fails = 0;
    int total_checks = 0;

    always #20 clk = ~clk;

    sts_supervisor #(.SLEEP_CYC(10)) i_sts_supervisor (.clk(clk), .rst(rst),
        .intSupplyGood(intSupplyGood), .mcuSupplyGood(mcuSupplyGood),
        .batOverVolt(batOverVolt), .batUnderVolt(batUnderVolt), .tempPrewarn(tempPrewarn),
        .tempShutdown(tempShutdown), .sleepRequestIn(sleepRequestIn),
        .watchdogReset(watchdogReset), .gateReq(gateReq), .gateOut(gateOut),
        .batteryPassSwitchOut(batteryPassSwitchOut), .supplyFaultFlag(supplyFaultFlag),
        .thermalWarningFlag(thermalWarningFlag), .mcuReset_n(mcuReset_n),
        .mcuRegEnable(mcuRegEnable), .linEnable(linEnable), .sleepMode(sleepMode));

    sts_mcu_model i_sts_mcu_model (.clk(clk), .mcuReset_n(mcuReset_n),
        .thermalWarningFlag(thermalWarningFlag), .sleepCmd(sleepCmd), .gateCmd(gateCmd),
        .sleepRequestIn(sleepRequestIn), .gateReq(gateReq));

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic t_boot;
        step(10);
        chk(batteryPassSwitchOut, 8'h01, "pass");
        chk({sleepMode, mcuReset_n, mcuRegEnable, linEnable}, 8'h07, "active");
        chk(gateOut, 8'h2D, "gates");
    endtask

    task automatic t_mcu;
        @(posedge clk);
        mcuSupplyGood <= 1'h0;
        step(6);
        chk(mcuReset_n, 8'h00, "mreset");
        chk(batteryPassSwitchOut, 8'h01, "pass");
        @(posedge clk);
        mcuSupplyGood <= 1'h1;
        step(8);
        chk(mcuReset_n, 8'h01, "mreset");
    endtask

    task automatic t_bat;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            batOverVolt <= (i == 0);
            batUnderVolt <= (i == 1);
            step(6);
            chk(gateOut, 8'h00, "gates");
            chk(supplyFaultFlag, 8'h01, "fault");
            @(posedge clk);
            batOverVolt <= 1'h0;
            batUnderVolt <= 1'h0;
            step(6);
            chk({supplyFaultFlag, gateOut}, 8'h2D, "fault");
        end
    endtask

    task automatic t_wdog;
        @(posedge clk);
        watchdogReset <= 1'h1;
        step(3);
        @(posedge clk);
        watchdogReset <= 1'h0;
        step(6);
        chk(batteryPassSwitchOut, 8'h01, "pass");
    endtask

    task automatic t_temp;
        @(posedge clk);
        tempPrewarn <= 1'h1;
        step(2);
        chk(thermalWarningFlag, 8'h00, "sync");
        step(6);
        chk({thermalWarningFlag, gateOut}, 8'h45, "warn");
        @(posedge clk);
        tempShutdown <= 1'h1;
        step(6);
        chk({mcuReset_n, mcuRegEnable, linEnable, gateOut}, 8'h00, "hot");
        chk(batteryPassSwitchOut, 8'h01, "pass");
        @(posedge clk);
        tempShutdown <= 1'h0;
        step(8);
        chk({mcuReset_n, mcuRegEnable, linEnable}, 8'h07, "cool");
        @(posedge clk);
        tempPrewarn <= 1'h0;
        step(8);
        chk({thermalWarningFlag, gateOut}, 8'h2D, "warn");
    endtask

    task automatic t_int;
        @(posedge clk);
        intSupplyGood <= 1'h0;
        step(6);
        chk({batteryPassSwitchOut, mcuReset_n, gateOut}, 8'h00, "core");
        @(posedge clk);
        intSupplyGood <= 1'h1;
        step(12);
        chk({batteryPassSwitchOut, mcuReset_n, sleepMode}, 8'h06, "boot");
    endtask

    // A short low pulse must not count as a sleep request
    task automatic t_sleep;
        @(posedge clk);
        sleepCmd <= 1'h0;
        step(4);
        @(posedge clk);
        sleepCmd <= 1'h1;
        step(24);
        chk(sleepMode, 8'h00, "short");
        @(posedge clk);
        sleepCmd <= 1'h0;
        step(24);
        chk({sleepMode, batteryPassSwitchOut}, 8'h02, "sleep");
    endtask

    task automatic wrap_up;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        t_boot();
        t_mcu();
        t_bat();
        t_wdog();
        t_temp();
        t_int();
        t_sleep();
        wrap_up();
    end
endmodule
`default_nettype wire
